// ===== dv/tb.sv
// testbench: register access, transmit, break, receive, wake, auto rate
// assumes the far-end model on the serial pins and a 250 MHz clock
`timescale 1ns/1ps
module tb;
	logic        clk, rst_n, bus_wr, bus_rd, idle_mode, sleep_mode, send_go;
	logic [7:0]  bus_addr, bit_clks, send_byte;
	logic [31:0] bus_wdata, rd_val;
	wire  [31:0] bus_rdata;
	wire  [7:0]  got_byte;
	wire         serial_in_pin, clear_to_send_pin, serial_out_pin;
	wire         serial_out_oe, request_to_send_pin, request_to_send_oe;
	wire         baud_clock_out_pin, baud_clock_out_oe, serial_in_owned;
	wire         clear_to_send_owned, wake_event, tx_irq, got_done;
	integer      fail_count, check_count, n;
	umsc_top dut (.clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
		.bus_rdata, .idle_mode, .sleep_mode, .serial_in_pin,
		.clear_to_send_pin, .serial_out_pin, .serial_out_oe,
		.request_to_send_pin, .request_to_send_oe, .baud_clock_out_pin,
		.baud_clock_out_oe, .serial_in_owned, .clear_to_send_owned,
		.wake_event, .tx_irq);
	umsc_far_end far (.clk, .bit_clks, .send_go, .send_byte,
		.tx_line(serial_out_pin), .tx_oe(serial_out_oe),
		.rx_line(serial_in_pin), .cts_n(clear_to_send_pin), .got_byte,
		.got_done);
	// 4 ns clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// register write, then one quiet cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
		@(posedge clk);
	endtask
	// register read, data taken in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 rd_val = bus_rdata;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// a wait that used up its bound ends the run as failed
	task automatic limit(input integer lim);
		if (n >= lim) begin
			fail_count = fail_count + 1;
			give_verdict();
		end
	endtask
	// ask the far end for one frame
	task automatic send(input logic [7:0] b);
		send_byte <= b;
		send_go <= 1'b1;
		@(posedge clk);
		send_go <= 1'b0;
		@(posedge clk);
	endtask
	// bounded wait for a decoded frame, then compare it
	task automatic wait_done(input logic [7:0] exp);
		n = 0;
		while (got_done !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n = n + 1;
		end
		limit(4000);
		chk(got_byte, exp);
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		{bus_wr, bus_rd, idle_mode, sleep_mode, send_go} = 5'h00;
		{bus_addr, send_byte, bus_wdata} = 48'h0;
		bit_clks = 8'd16;
		fail_count = 0;
		check_count = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(8'h00); chk(rd_val, 32'h00000000);
		rd(8'h10); chk(rd_val, 32'h00000110);
		rd(8'h50); chk(rd_val, 32'h00000000);
		wr(8'h00, 32'hffff7fff); rd(8'h00); chk(rd_val, 32'h00003bff);
		wr(8'h10, 32'hfffffbff); rd(8'h10); chk(rd_val, 32'h01fff9f0);
		wr(8'h10, 32'h0); wr(8'h00, 32'h0);
		// pin usage codes and transmit irq selects
		for (n = 0; n < 4; n = n + 1) begin
			wr(8'h00, 32'h8000 | (n << 8));
			repeat (2) @(posedge clk);
			chk({request_to_send_oe, baud_clock_out_oe, clear_to_send_owned},
				{n == 1 || n == 2, n == 3, n == 2});
		end
		wr(8'h00, 32'h8000);
		for (n = 0; n < 4; n = n + 1) begin
			wr(8'h10, 32'h1400 | (n << 14));
			repeat (2) @(posedge clk);
			chk(tx_irq, n != 3);
		end
		// nine back-to-back characters fill the queue
		for (n = 0; n < 9; n = n + 1)
			wr(8'h20, 32'h30 + n);
		rd(8'h10); chk(rd_val[9:8], 2'b10);
		wait_done(8'h30);
		wr(8'h10, 32'h1000);
		rd(8'h10); chk(rd_val[9:8], 2'b01);
		chk(serial_out_oe, 1'b0);
		repeat (300) @(posedge clk);
		// break: start plus twelve zeros low in one stretch
		wr(8'h10, 32'h1c00); wr(8'h20, 32'h0);
		n = 0;
		while (serial_out_pin !== 1'b0 && n < 500) begin
			@(posedge clk);
			n = n + 1;
		end
		limit(500);
		n = 0;
		while (serial_out_pin === 1'b0 && n < 500) begin
			@(posedge clk);
			n = n + 1;
		end
		limit(500);
		chk(n, 13 * 16);
		repeat (400) @(posedge clk);
		rd(8'h10); chk(rd_val[11], 1'b0);
		// receive one frame
		send(8'h3c);
		repeat (200) @(posedge clk);
		rd(8'h30); chk(rd_val[8:0], 9'h03c);
		chk(request_to_send_pin, 1'b0);
		// wake on start bit during sleep, request pin in simplex
		wr(8'h00, 32'h8880);
		sleep_mode <= 1'b1;
		send(8'hff);
		n = 0;
		while (wake_event !== 1'b1 && n < 100) begin
			@(posedge clk);
			n = n + 1;
		end
		limit(100);
		chk(wake_event, 1'b1);
		chk(request_to_send_pin, 1'b1);
		sleep_mode <= 1'b0;
		repeat (200) @(posedge clk);
		rd(8'h30); chk(rd_val[8:0], 9'h0ff);
		// loopback: transmitted character returns to the receive queue
		wr(8'h00, 32'h8040); wr(8'h20, 32'h5a);
		repeat (200) @(posedge clk);
		rd(8'h30); chk(rd_val[8:0], 9'h05a);
		// auto rate on a sync character at 32 clocks a bit
		wr(8'h00, 32'h8020);
		bit_clks <= 8'd32;
		send(8'h55);
		repeat (400) @(posedge clk);
		rd(8'h00); chk(rd_val[5], 1'b0);
		rd(8'h40); chk(rd_val, 32'h00000001);
		// transmit idle level with and without infrared coding
		wr(8'h10, 32'h2400);
		repeat (2) @(posedge clk);
		chk(serial_out_pin, 1'b0);
		wr(8'h00, 32'h9000);
		repeat (2) @(posedge clk);
		chk(serial_out_pin, 1'b1);
		// rate generator ticks every other clock, then freezes in idle
		wr(8'h00, 32'ha000);
		rd_val[0] = baud_clock_out_pin;
		repeat (2) @(posedge clk);
		chk(baud_clock_out_pin, !rd_val[0]);
		idle_mode <= 1'b1;
		repeat (3) @(posedge clk);
		rd_val[0] = baud_clock_out_pin;
		repeat (2) @(posedge clk);
		chk(baud_clock_out_pin, rd_val[0]);
		idle_mode <= 1'b0;
		give_verdict();
	end
endmodule

// ===== dv/umsc_asserts.sv
// checker: pin ownership, read data and event relations at the ports
// assumes it is bound to umsc_top and shares its clock and reset
`timescale 1ns/1ps
module umsc_checker (
	input wire        clk,
	input wire        rst_n,
	input wire [7:0]  bus_addr,
	input wire [31:0] bus_wdata,
	input wire        bus_wr,
	input wire        bus_rd,
	input wire [31:0] bus_rdata,
	input wire        serial_out_oe,
	input wire        request_to_send_oe,
	input wire        baud_clock_out_oe,
	input wire        serial_in_owned,
	input wire        clear_to_send_owned,
	input wire        wake_event,
	input wire        tx_irq
);
	reg  [15:0] mode_q;
	reg  [15:0] sta_q;
	reg  [6:0]  own_q;
	wire        mapped;
	wire        on;
	assign mapped = bus_addr[3:0] == 4'h0 && bus_addr[7:4] <= 4'h4;
	assign on = mode_q[15];
	// shadow of written fields, then expected ownership one cycle on
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 16'h0000;
			sta_q <= 16'h0000;
			own_q <= 7'h00;
		end else begin
			if (bus_wr && bus_addr == 8'h00)
				mode_q <= bus_wdata[15:0];
			if (bus_wr && bus_addr == 8'h10)
				sta_q <= bus_wdata[15:0];
			own_q <= {sta_q[15:14] == 2'b11, on & mode_q[7],
				on & (mode_q[9:8] == 2'b10), on & (mode_q[9:8] == 2'b11),
				on & (mode_q[9:8] == 2'b01 || mode_q[9:8] == 2'b10),
				on & sta_q[12], on & sta_q[10]};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	tx_pin_own_a: assert property (serial_out_oe == own_q[0])
		else $error("transmit pin ownership wrong");
	rx_pin_own_a: assert property (serial_in_owned == own_q[1])
		else $error("receive pin ownership wrong");
	rts_pin_own_a: assert property (request_to_send_oe == own_q[2])
		else $error("request pin ownership wrong");
	bclk_pin_own_a: assert property (baud_clock_out_oe == own_q[3])
		else $error("baud clock pin ownership wrong");
	cts_pin_own_a: assert property (clear_to_send_owned == own_q[4])
		else $error("clear pin ownership wrong");
	wake_pulse_a: assert property (wake_event |-> own_q[5] ##1 !wake_event)
		else $error("wake pulse without enable or too long");
	irq_reserved_a: assert property (own_q[6] |-> !tx_irq)
		else $error("transmit irq raised on reserved select");
	rdata_rest_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
		else $error("read data outside its cycle");
	unmapped_zero_a: assert property ($past(bus_rd) && !$past(mapped)
		|-> bus_rdata == 32'h0) else $error("unmapped read not zero");
	mode_gaps_a: assert property ($past(bus_rd) && $past(bus_addr) == 8'h00
		|-> bus_rdata[31:16] == 16'h0 && bus_rdata[14] == 1'b0
		&& bus_rdata[10] == 1'b0) else $error("mode gap bits not zero");
endmodule
bind umsc_top umsc_checker u_chk (.clk, .rst_n, .bus_addr, .bus_wdata,
	.bus_wr, .bus_rd, .bus_rdata, .serial_out_oe, .request_to_send_oe,
	.baud_clock_out_oe, .serial_in_owned, .clear_to_send_owned,
	.wake_event, .tx_irq);

// ===== dv/umsc_far_end.sv
// far-end serial device: sends frames on request, decodes received ones
// assumes an idle-high line, one start, eight data bits and one stop
`timescale 1ns/1ps
module umsc_far_end (
	input  wire       clk,
	input  wire [7:0] bit_clks,
	input  wire       send_go,
	input  wire [7:0] send_byte,
	input  wire       tx_line,
	input  wire       tx_oe,
	output reg        rx_line,
	output reg        cts_n,
	output reg  [7:0] got_byte,
	output reg        got_done
);
	integer i;
	integer j;
	// idle line high, always ready to take data
	initial begin
		rx_line = 1'b1;
		cts_n = 1'b0;
		got_byte = 8'h00;
		got_done = 1'b0;
	end
	// frame out: start low, data lsb first, stop high
	always @(posedge clk) begin
		if (send_go) begin
			rx_line <= 1'b0;
			repeat (bit_clks) @(posedge clk);
			for (i = 0; i < 8; i = i + 1) begin
				rx_line <= send_byte[i];
				repeat (bit_clks) @(posedge clk);
			end
			rx_line <= 1'b1;
			repeat (bit_clks) @(posedge clk);
		end
	end
	// frame in: sample each data bit near its middle
	always @(posedge clk) begin
		if (tx_oe && tx_line === 1'b0) begin
			repeat (bit_clks / 2) @(posedge clk);
			for (j = 0; j < 8; j = j + 1) begin
				repeat (bit_clks) @(posedge clk);
				got_byte[j] <= tx_line;
			end
			repeat (bit_clks) @(posedge clk);
			got_done <= 1'b1;
			@(posedge clk);
			got_done <= 1'b0;
		end
	end
endmodule

// ===== inc/umsc_defs.vh
// constants of the serial mode/status control block
// assumes a byte address bus and a single 250 MHz clock
`ifndef UMSC_DEFS_VH
`define UMSC_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define UMSC_OFS_MODE  8'h00
`define UMSC_OFS_STA   8'h10
`define UMSC_OFS_TXD   8'h20
`define UMSC_OFS_RXD   8'h30
`define UMSC_OFS_BRG   8'h40

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define UMSC_MODE_RST   16'h0000
`define UMSC_MODE_WMASK 16'hbbff
`define UMSC_M_ON       15
`define UMSC_M_STOP_IN_IDLE     13
`define UMSC_M_INFRARED_CODING_ENABLE     12
`define UMSC_M_REQUEST_PIN_MODE    11
`define UMSC_M_UEN      9:8
`define UMSC_M_WAKE     7
`define UMSC_M_LOOPBACK_SELECT   6
`define UMSC_M_AUTO_RATE_MEASURE    5
`define UMSC_M_RECEIVE_POLARITY    4
`define UMSC_M_HIGH_SPEED_OVERSAMPLE     3
`define UMSC_M_PDSEL    2:1
`define UMSC_M_STOP_BIT_COUNT    0

// ----------------------------------------
// status register fields
// ----------------------------------------
`define UMSC_STA_RST    32'h00000000
`define UMSC_STA_WMASK  32'h01fffce0
`define UMSC_S_ADMEN    24
`define UMSC_S_ADDR     23:16
`define UMSC_S_TXIS     15:14
`define UMSC_S_TXINV    13
`define UMSC_S_RXEN     12
`define UMSC_S_BRK      11
`define UMSC_S_TXEN     10
`define UMSC_S_RXIS     7:6
`define UMSC_S_ADDEN    5
`define UMSC_S_OERR     1
`define UMSC_BRG_RST    16'h0000

// ----------------------------------------
// field encodings
// ----------------------------------------
`define UMSC_UEN_RTS    2'b01
`define UMSC_UEN_FLOW   2'b10
`define UMSC_UEN_BCLK   2'b11
`define UMSC_PD_8N      2'b00
`define UMSC_PD_8E      2'b01
`define UMSC_PD_8O      2'b10
`define UMSC_PD_9N      2'b11
`define UMSC_TXI_SPACE  2'b00
`define UMSC_TXI_DONE   2'b01
`define UMSC_TXI_EMPTY  2'b10

// ----------------------------------------
// frame and timing counts
// ----------------------------------------
`define UMSC_DEPTH      4'd8
`define UMSC_BASE_BITS  4'd9
`define UMSC_BRK_FRAME  15'h6000
`define UMSC_BRK_LEFT   4'd13
`define UMSC_OS16_LAST  4'd15
`define UMSC_OS4_LAST   4'd3
`define UMSC_AB_EDGES   3'd3
`define UMSC_AB_SH16    7
`define UMSC_AB_SH4     5

`endif

// ===== src/umsc_ram.v
// eight-word queue storage with registered read data
// assumes one writer and one reader on the same clock
`timescale 1ns/1ps
module umsc_ram (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        we,
	input  wire [2:0]  waddr,
	input  wire [10:0] wdata,
	input  wire [2:0]  raddr,
	output reg  [10:0] rdata
);

	reg [10:0] mem [0:7];

	// write port
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 11'h000;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule

// ===== src/umsc_top.v
// serial transceiver mode/status control with queues and shifters
// assumes a one-cycle register port and pins from outside the clock
`timescale 1ns/1ps
`include "umsc_defs.vh"
module umsc_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [7:0]  bus_addr,
	input  wire [31:0] bus_wdata,
	input  wire        bus_wr,
	input  wire        bus_rd,
	output reg  [31:0] bus_rdata,
	input  wire        idle_mode,
	input  wire        sleep_mode,
	input  wire        serial_in_pin,
	input  wire        clear_to_send_pin,
	output reg         serial_out_pin,
	output reg         serial_out_oe,
	output reg         request_to_send_pin,
	output reg         request_to_send_oe,
	output reg         baud_clock_out_pin,
	output reg         baud_clock_out_oe,
	output reg         serial_in_owned,
	output reg         clear_to_send_owned,
	output reg         wake_event,
	output reg         tx_irq
);

	localparam TX_IDLE = 1'b0;
	localparam TX_SEND = 1'b1;
	localparam RX_IDLE = 1'b0;
	localparam RX_RECV = 1'b1;

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// total bits of one frame, start through stop
	function [3:0] frame_len;
		input [1:0] pd;
		input       st;
		begin
			frame_len = `UMSC_BASE_BITS + {3'b000, pd != `UMSC_PD_8N}
				+ {3'b000, st} + 4'd1;
		end
	endfunction

	// frame image, bit 0 goes out first
	function [14:0] build_frame;
		input [8:0] d;
		input [1:0] pd;
		reg         ext;
		begin
			ext = ^d[7:0];
			if (pd == `UMSC_PD_9N) begin
				ext = d[8];
			end else if (pd == `UMSC_PD_8O) begin
				ext = ~^d[7:0];
			end
			if (pd == `UMSC_PD_8N) begin
				build_frame = {6'h3f, d[7:0], 1'b0};
			end else begin
				build_frame = {5'h1f, ext, d[7:0], 1'b0};
			end
		end
	endfunction

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	reg  [15:0] mode_q;
	reg  [31:0] sta_w_q;
	reg         oerr_q;
	reg  [15:0] brg_q;
	reg  [15:0] brg_cnt_q;
	reg  [1:0]  rx_sync_q;
	reg  [1:0]  cts_sync_q;
	reg         tx_st_q;
	reg  [14:0] tx_sh_q;
	reg  [3:0]  tx_left_q;
	reg  [3:0]  tx_ph_q;
	reg         tx_brk_q;
	reg         tx_avail_q;
	reg  [2:0]  tx_wp_q;
	reg  [2:0]  tx_rp_q;
	reg  [3:0]  tx_cnt_q;
	reg         rx_st_q;
	reg  [3:0]  rx_ph_q;
	reg  [3:0]  rx_idx_q;
	reg  [9:0]  rx_sh_q;
	reg         rx_prev_q;
	reg  [3:0]  ir_hold_q;
	reg         addressed_q;
	reg  [2:0]  rx_wp_q;
	reg  [2:0]  rx_rp_q;
	reg  [3:0]  rx_cnt_q;
	reg         ab_run_q;
	reg  [2:0]  ab_edges_q;
	reg  [19:0] ab_cnt_q;
	reg         bclk_q;
	wire [10:0] tx_q;
	wire [10:0] rx_q;

	// ----------------------------------------
	// control decode
	// ----------------------------------------
	wire       on     = mode_q[`UMSC_M_ON];
	wire [1:0] uen    = mode_q[`UMSC_M_UEN];
	wire [1:0] pd     = mode_q[`UMSC_M_PDSEL];
	wire       infrared_coding_enable   = mode_q[`UMSC_M_INFRARED_CODING_ENABLE];
	wire       auto_rate_measure  = mode_q[`UMSC_M_AUTO_RATE_MEASURE];
	wire       high_speed_oversample   = mode_q[`UMSC_M_HIGH_SPEED_OVERSAMPLE];
	wire       txen   = sta_w_q[`UMSC_S_TXEN];
	wire       rxen   = sta_w_q[`UMSC_S_RXEN];
	wire       txinv  = sta_w_q[`UMSC_S_TXINV];
	wire       admen  = sta_w_q[`UMSC_S_ADMEN];
	wire       adden  = sta_w_q[`UMSC_S_ADDEN];
	wire [7:0] addr   = sta_w_q[`UMSC_S_ADDR];
	wire       wr_mode = bus_wr && bus_addr == `UMSC_OFS_MODE;
	wire       wr_sta  = bus_wr && bus_addr == `UMSC_OFS_STA;
	wire       wr_txd  = bus_wr && bus_addr == `UMSC_OFS_TXD;
	wire       wr_brg  = bus_wr && bus_addr == `UMSC_OFS_BRG;
	wire       rd_rxd  = bus_rd && bus_addr == `UMSC_OFS_RXD;
	// halted when off, or in idle mode while the stop-in-idle bit is set
	wire       run    = on && !(mode_q[`UMSC_M_STOP_IN_IDLE] && idle_mode);
	wire       tx_rst = !on || !txen;
	wire       rx_act = run && rxen;
	wire [3:0] os_last = high_speed_oversample ? `UMSC_OS4_LAST : `UMSC_OS16_LAST;
	wire       samp_tick = run && brg_cnt_q == brg_q;
	wire       tx_full  = tx_cnt_q == `UMSC_DEPTH;
	wire       rx_full  = rx_cnt_q == `UMSC_DEPTH;
	wire       shift_empty_flag     = tx_st_q == TX_IDLE && tx_cnt_q == 4'd0;
	wire       tx_lvl   = tx_st_q == TX_SEND ? tx_sh_q[0] : 1'b1;
	wire       cts_ok   = uen != `UMSC_UEN_FLOW || !cts_sync_q[1];
	wire       tx_push  = wr_txd && !tx_full && !tx_rst;
	wire       tx_go    = run && !tx_rst && tx_st_q == TX_IDLE
		&& (sta_w_q[`UMSC_S_BRK] || (tx_avail_q && tx_cnt_q != 4'd0
		&& cts_ok));
	wire       tx_pop   = tx_go && !sta_w_q[`UMSC_S_BRK];
	wire       tx_bit_end = tx_st_q == TX_SEND && samp_tick
		&& tx_ph_q == os_last;
	wire       tx_done  = tx_bit_end && tx_left_q == 4'd0;
	wire       brk_done = tx_done && tx_brk_q;
	wire [2:0] tx_rp_d  = tx_rp_q + {2'b00, tx_pop};

	// ----------------------------------------
	// receive line conditioning
	// ----------------------------------------
	// departure from idle level counts as an infrared pulse
	wire       rx_pol   = rx_sync_q[1] ^ mode_q[`UMSC_M_RECEIVE_POLARITY];
	wire       ir_lvl   = rx_pol && ir_hold_q == 4'd0;
	wire       rx_pin_lvl = infrared_coding_enable ? ir_lvl : rx_pol;
	wire       rx_lvl   = mode_q[`UMSC_M_LOOPBACK_SELECT] ? tx_lvl : rx_pin_lvl;
	wire       rx_fall  = rx_prev_q && !rx_lvl;
	wire       rx_samp  = rx_st_q == RX_RECV && samp_tick
		&& rx_ph_q == {1'b0, os_last[3:1]};
	wire [3:0] rx_last  = frame_len(pd, 1'b0) - 4'd1;
	wire       rx_end   = rx_samp && rx_idx_q == rx_last;
	wire [7:0] rx_d8    = pd == `UMSC_PD_8N ? rx_sh_q[9:2] : rx_sh_q[8:1];
	wire       rx_ext   = rx_sh_q[9];
	wire       rx_perr  = (pd == `UMSC_PD_8E && rx_ext != ^rx_d8)
		|| (pd == `UMSC_PD_8O && rx_ext != ~^rx_d8);
	wire       nine     = pd == `UMSC_PD_9N;
	wire       is_addr  = nine && rx_ext;
	wire       match    = !admen || rx_d8 == addr;
	wire       filt     = nine && (adden || admen);
	wire       keep     = !filt || (is_addr ? match : (admen && addressed_q));
	wire       rx_store = rx_end && keep && !rx_full;
	wire       rx_ovf   = rx_end && keep && rx_full;
	wire       rx_clr   = wr_sta && !bus_wdata[`UMSC_S_OERR] && oerr_q;
	wire       rx_rst   = !on || (rx_clr && !rx_ovf); // set wins, no flush
	wire       rx_pop   = rd_rxd && rx_cnt_q != 4'd0;
	wire [2:0] rx_rp_d  = rx_rp_q + {2'b00, rx_pop};
	wire       ab_done  = ab_run_q && rx_fall && ab_edges_q == `UMSC_AB_EDGES;
	wire [19:0] ab_val  = high_speed_oversample ? ab_cnt_q >> `UMSC_AB_SH4
		: ab_cnt_q >> `UMSC_AB_SH16;
	wire [10:0] rx_word = {!rx_lvl, rx_perr, nine & rx_ext, rx_d8};

	// ----------------------------------------
	// queue storage
	// ----------------------------------------
	umsc_ram u_tx_ram (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (tx_push),
		.waddr (tx_wp_q),
		.wdata ({2'b00, bus_wdata[8:0]}),
		.raddr (tx_rp_d),
		.rdata (tx_q)
	);

	umsc_ram u_rx_ram (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (rx_store),
		.waddr (rx_wp_q),
		.wdata (rx_word),
		.raddr (rx_rp_d),
		.rdata (rx_q)
	);

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	// mode, status control, prescaler; hardware clears two bits
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q  <= `UMSC_MODE_RST;
			sta_w_q <= `UMSC_STA_RST;
			oerr_q  <= 1'b0;
			brg_q   <= `UMSC_BRG_RST;
		end else begin
			if (wr_mode) begin
				mode_q <= bus_wdata[15:0] & `UMSC_MODE_WMASK;
			end else if (ab_done) begin
				mode_q[`UMSC_M_AUTO_RATE_MEASURE] <= 1'b0;
			end
			if (wr_sta) begin
				sta_w_q <= bus_wdata & `UMSC_STA_WMASK;
			end else if (brk_done) begin
				sta_w_q[`UMSC_S_BRK] <= 1'b0;
			end
			if (rx_ovf) begin
				oerr_q <= 1'b1;
			end else if (rx_clr) begin
				oerr_q <= 1'b0;
			end
			if (wr_brg) begin
				brg_q <= bus_wdata[15:0];
			end else if (ab_done) begin
				brg_q <= ab_val[15:0] - 16'h0001;
			end
		end
	end

	// read data, one cycle after the strobe
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 32'h00000000;
		end else if (bus_rd) begin
			case (bus_addr)
				`UMSC_OFS_MODE: bus_rdata <= {16'h0000, mode_q};
				`UMSC_OFS_STA: bus_rdata <= {sta_w_q[31:10], tx_full,
					shift_empty_flag, sta_w_q[7:5], rx_st_q == RX_IDLE,
					rx_q[9], rx_q[10], oerr_q, rx_cnt_q != 4'd0};
				`UMSC_OFS_RXD: bus_rdata <= {23'h000000, rx_q[8:0]};
				`UMSC_OFS_BRG: bus_rdata <= {16'h0000, brg_q};
				default: bus_rdata <= 32'h00000000;
			endcase
		end else begin
			bus_rdata <= 32'h00000000;
		end
	end

	// ----------------------------------------
	// pin synchronisers and rate generator
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_q  <= 2'b11;
			cts_sync_q <= 2'b11;
			brg_cnt_q  <= 16'h0000;
			bclk_q     <= 1'b0;
		end else begin
			rx_sync_q  <= {rx_sync_q[0], serial_in_pin};
			cts_sync_q <= {cts_sync_q[0], clear_to_send_pin};
			if (!run) begin
				brg_cnt_q <= 16'h0000;
			end else begin
				brg_cnt_q <= samp_tick ? 16'h0000 : brg_cnt_q + 16'h0001;
			end
			if (samp_tick) begin
				bclk_q <= !bclk_q;
			end
		end
	end

	// ----------------------------------------
	// transmit queue and shifter
	// ----------------------------------------
	// queue data need a cycle to reach the read register
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_wp_q    <= 3'd0;
			tx_rp_q    <= 3'd0;
			tx_cnt_q   <= 4'd0;
			tx_avail_q <= 1'b0;
		end else if (tx_rst) begin
			tx_wp_q    <= 3'd0;
			tx_rp_q    <= 3'd0;
			tx_cnt_q   <= 4'd0;
			tx_avail_q <= 1'b0;
		end else begin
			tx_wp_q    <= tx_wp_q + {2'b00, tx_push};
			tx_rp_q    <= tx_rp_d;
			tx_cnt_q   <= tx_cnt_q + {3'b000, tx_push} - {3'b000, tx_pop};
			tx_avail_q <= tx_cnt_q != 4'd0 && !tx_pop;
		end
	end

	// frame shifter, one bit per oversample period
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_q   <= TX_IDLE;
			tx_sh_q   <= 15'h7fff;
			tx_left_q <= 4'd0;
			tx_ph_q   <= 4'd0;
			tx_brk_q  <= 1'b0;
		end else if (tx_rst) begin
			tx_st_q <= TX_IDLE;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					if (tx_go) begin
						tx_st_q  <= TX_SEND;
						tx_ph_q  <= 4'd0;
						tx_brk_q <= sta_w_q[`UMSC_S_BRK];
						if (sta_w_q[`UMSC_S_BRK]) begin
							tx_sh_q   <= `UMSC_BRK_FRAME;
							tx_left_q <= `UMSC_BRK_LEFT;
						end else begin
							tx_sh_q   <= build_frame(tx_q[8:0], pd);
							tx_left_q <= frame_len(pd,
								mode_q[`UMSC_M_STOP_BIT_COUNT]) - 4'd1;
						end
					end
				end
				TX_SEND: begin
					if (samp_tick) begin
						tx_ph_q <= tx_bit_end ? 4'd0 : tx_ph_q + 4'd1;
					end
					if (tx_done) begin
						tx_st_q <= TX_IDLE;
					end else if (tx_bit_end) begin
						tx_sh_q   <= {1'b1, tx_sh_q[14:1]};
						tx_left_q <= tx_left_q - 4'd1;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// receive queue, shifter, auto-rate
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp_q  <= 3'd0;
			rx_rp_q  <= 3'd0;
			rx_cnt_q <= 4'd0;
		end else if (rx_rst) begin
			rx_wp_q  <= 3'd0;
			rx_rp_q  <= 3'd0;
			rx_cnt_q <= 4'd0;
		end else begin
			rx_wp_q  <= rx_wp_q + {2'b00, rx_store};
			rx_rp_q  <= rx_rp_d;
			rx_cnt_q <= rx_cnt_q + {3'b000, rx_store} - {3'b000, rx_pop};
		end
	end

	// mid-bit sampler; false start returns to idle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q     <= RX_IDLE;
			rx_ph_q     <= 4'd0;
			rx_idx_q    <= 4'd0;
			rx_sh_q     <= 10'h000;
			addressed_q <= 1'b0;
		end else if (!rx_act || auto_rate_measure) begin
			rx_st_q <= RX_IDLE;
		end else begin
			case (rx_st_q)
				RX_IDLE: begin
					if (!rx_lvl) begin
						rx_st_q  <= RX_RECV;
						rx_ph_q  <= 4'd0;
						rx_idx_q <= 4'd0;
					end
				end
				RX_RECV: begin
					if (samp_tick) begin
						rx_ph_q <= rx_ph_q == os_last ? 4'd0 : rx_ph_q + 4'd1;
					end
					if (rx_samp) begin
						rx_idx_q <= rx_idx_q + 4'd1;
						if (rx_idx_q == 4'd0 && rx_lvl) begin
							rx_st_q <= RX_IDLE;
						end else if (rx_end) begin
							rx_st_q <= RX_IDLE;
							if (is_addr) begin
								addressed_q <= match;
							end
						end else if (rx_idx_q != 4'd0) begin
							rx_sh_q <= {rx_lvl, rx_sh_q[9:1]};
						end
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// sync char: five falling edges span eight bit times
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ab_run_q   <= 1'b0;
			ab_edges_q <= 3'd0;
			ab_cnt_q   <= 20'h00000;
			rx_prev_q  <= 1'b1;
			ir_hold_q  <= 4'd0;
		end else begin
			rx_prev_q <= rx_lvl;
			if (!rx_pol) begin
				ir_hold_q <= os_last;
			end else if (samp_tick && ir_hold_q != 4'd0) begin
				ir_hold_q <= ir_hold_q - 4'd1;
			end
			if (!rx_act || !auto_rate_measure || ab_done) begin
				ab_run_q <= 1'b0;
			end else if (rx_fall && !ab_run_q) begin
				ab_run_q   <= 1'b1;
				ab_edges_q <= 3'd0;
				ab_cnt_q   <= 20'h00001; // this clock counts too
			end else if (ab_run_q) begin
				ab_cnt_q <= ab_cnt_q + 20'h00001;
				if (rx_fall) begin
					ab_edges_q <= ab_edges_q + 3'd1;
				end
			end
		end
	end

	// ----------------------------------------
	// pin drivers and status outputs
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_pin      <= 1'b1;
			serial_out_oe       <= 1'b0;
			request_to_send_pin <= 1'b1;
			request_to_send_oe  <= 1'b0;
			baud_clock_out_pin  <= 1'b0;
			baud_clock_out_oe   <= 1'b0;
			serial_in_owned     <= 1'b0;
			clear_to_send_owned <= 1'b0;
			wake_event          <= 1'b0;
			tx_irq              <= 1'b0;
		end else begin
			serial_out_oe <= on && txen;
			if (infrared_coding_enable) begin
				serial_out_pin <= (!tx_lvl && tx_ph_q <= {2'b00,
					os_last[3:2]}) ^ txinv;
			end else begin
				serial_out_pin <= tx_lvl ^ txinv;
			end
			request_to_send_oe <= on && (uen == `UMSC_UEN_RTS
				|| uen == `UMSC_UEN_FLOW);
			if (mode_q[`UMSC_M_REQUEST_PIN_MODE]) begin
				request_to_send_pin <= shift_empty_flag;
			end else begin
				request_to_send_pin <= !(rx_act && !rx_full);
			end
			baud_clock_out_oe   <= on && uen == `UMSC_UEN_BCLK;
			baud_clock_out_pin  <= bclk_q;
			clear_to_send_owned <= on && uen == `UMSC_UEN_FLOW;
			serial_in_owned     <= on && rxen;
			wake_event <= on && mode_q[`UMSC_M_WAKE] && sleep_mode
				&& rx_fall;
			case (sta_w_q[`UMSC_S_TXIS])
				`UMSC_TXI_SPACE: tx_irq <= !tx_full;
				`UMSC_TXI_DONE:  tx_irq <= shift_empty_flag;
				`UMSC_TXI_EMPTY: tx_irq <= tx_cnt_q == 4'd0;
				default:         tx_irq <= 1'b0;
			endcase
		end
	end

endmodule
